// [include/slmc_defs.svh]
`ifndef SLMC_DEFS_SVH
`define SLMC_DEFS_SVH

// printed offsets are not multiples of four: they are register indices
`define SLMC_IDX_LOCK_FLAGS   16'hf580
`define SLMC_IDX_MUTE_CONTROL 16'hf581
// extra registers for the interrupt block
`define SLMC_IDX_IRQ_STATUS   16'hf582
`define SLMC_IDX_IRQ_MASK     16'hf583

`define SLMC_LOCK_FLAGS_RESET 16'h0000
`define SLMC_MUTE_RESET       16'h0000
`define SLMC_IRQ_MASK_RESET   16'h0000

`define SLMC_MUTE_MANUAL_LSB  0
`define SLMC_MUTE_RAMP0_BIT   8
`define SLMC_MUTE_RAMP1_BIT   9
`define SLMC_MUTE_AUTO_BIT    10
`define SLMC_MUTE_WMASK       16'h07ff

// irq status layout: [7:0] lock gained, [15:8] lock lost
`define SLMC_IRQ_GAIN_LSB     0
`define SLMC_IRQ_LOSS_LSB     8

`define SLMC_RAMP_SAMPLES     2048
`define SLMC_GAIN_FULL        12'h800

`endif

// [include/slmc_pkg.sv]
package slmc_pkg;

  typedef logic [11:0] slmc_gain_t;

  typedef struct packed {
    logic [7:0] rateSet;
    logic [7:0] inputStable;
    logic [7:0] ratioDone;
  } slmc_lock_cond_t;

  typedef struct packed {
    logic [7:0] manualMute;
    logic [1:0] rampDisable;
    logic       autoMute;
  } slmc_mute_ctrl_t;

  typedef enum logic [1:0] {
    SLMC_IDLE   = 2'b00,
    SLMC_ACCESS = 2'b01
  } slmc_apb_state_t;

endpackage : slmc_pkg

// [src/slmc_lock_mute.sv]
`timescale 1ns/1ps
`include "slmc_defs.svh"

// Behaviour
// - eight lock flags, bit n is pair n
// - lock needs rate, stable input, ratio
// - lock flags read-only, reset zero
// - low byte holds per-pair manual mutes
// - bits 8, 9 disable group ramping
// - mute and unmute gain moves linearly
// - ramp lasts 2048 input samples
// - bit 10 auto-mutes unlocked pairs
// - auto mute ramps, never steps
// - regained lock unmutes through ramp
// - manual mute overrides auto behaviour
// - bit 10 clear: manual mute only
// - bit 8 pairs 0-3, bit 9 pairs 4-7
// - group disable bit keeps outputs active
module slmc_lock_mute (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [31:0]              paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire slmc_pkg::slmc_lock_cond_t lockCond,
  input  wire logic [7:0]               sampleTick,
  output logic      [8*12-1:0]          pairGain,
  output logic      [7:0]               pairMuted,
  output logic                          irq
);

  // ======================================================================
  // input synchronisers (converter status comes from other domains)
  // ======================================================================
  logic [23:0] condMeta_r;
  logic [23:0] condSync_r;
  logic [7:0]  tickMeta_r;
  logic [7:0]  tickSync_r;
  logic [7:0]  tickPrev_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      condMeta_r <= 24'h000000;
      condSync_r <= 24'h000000;
      tickMeta_r <= 8'h00;
      tickSync_r <= 8'h00;
      tickPrev_r <= 8'h00;
    end else begin
      condMeta_r <= lockCond;
      condSync_r <= condMeta_r;
      tickMeta_r <= sampleTick;
      tickSync_r <= tickMeta_r;
      tickPrev_r <= tickSync_r;
    end
  end

  slmc_pkg::slmc_lock_cond_t condS;
  logic [7:0] sampleStep;
  assign condS      = condSync_r;
  // each input sample toggles its tick line, so either edge is one sample
  assign sampleStep = tickSync_r ^ tickPrev_r;

  // ======================================================================
  // lock flags and mute targets
  // ======================================================================
  logic [7:0] lock_r;
  logic [7:0] lock_nxt;
  logic [7:0] manual_r;
  logic [7:0] manual_nxt;
  logic [1:0] rampDis_r;
  logic [1:0] rampDis_nxt;
  logic       autoMute_r;
  logic       autoMute_nxt;

  always_comb begin
    lock_nxt = condS.rateSet & condS.inputStable & condS.ratioDone;
  end

  function automatic logic groupDis(input logic [1:0] dis, input int pair);
    groupDis = (pair < 4) ? dis[0] : dis[1];
  endfunction : groupDis

  logic [7:0] wantMute;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (groupDis(rampDis_r, i)) begin
        wantMute[i] = 1'b0;
      end else if (manual_r[i]) begin
        wantMute[i] = 1'b1;
      end else begin
        wantMute[i] = autoMute_r & ~lock_r[i];
      end
    end
  end

  // ======================================================================
  // per-pair linear gain ramps
  // ======================================================================
  slmc_pkg::slmc_gain_t gain_r   [8];
  slmc_pkg::slmc_gain_t gain_nxt [8];

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      gain_nxt[i] = gain_r[i];
      if (groupDis(rampDis_r, i)) begin
        gain_nxt[i] = `SLMC_GAIN_FULL;
      end else if (sampleStep[i]) begin
        // direction follows the live target, so a reversal starts at the current gain
        if (wantMute[i] && gain_r[i] != 12'h000) begin
          gain_nxt[i] = gain_r[i] - 12'h001;
        end else if (!wantMute[i] && gain_r[i] != `SLMC_GAIN_FULL) begin
          gain_nxt[i] = gain_r[i] + 12'h001;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        gain_r[i] <= `SLMC_GAIN_FULL;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        gain_r[i] <= gain_nxt[i];
      end
    end
  end

  // ======================================================================
  // apb slave, one wait state, index*4 byte addressing
  // ======================================================================
  slmc_pkg::slmc_apb_state_t apbState_r;
  slmc_pkg::slmc_apb_state_t apbState_nxt;
  logic [31:0] prdata_nxt;
  logic        pready_nxt;
  logic        pslverr_nxt;
  logic [15:0] irqStat_r;
  logic [15:0] irqStat_nxt;
  logic [15:0] irqMask_r;
  logic [15:0] irqMask_nxt;
  logic        irq_nxt;

  function automatic logic isIdx(input logic [31:0] a, input logic [15:0] idx);
    isIdx = (a[1:0] == 2'b00) && (a[31:2] == {14'h0000, idx});
  endfunction : isIdx

  logic        accPhase;
  logic        wrHit;
  logic        rdHit;
  logic [15:0] wrData;
  assign accPhase = psel && penable && apbState_r == slmc_pkg::SLMC_ACCESS;
  assign wrHit    = accPhase && pwrite;
  assign rdHit    = accPhase && !pwrite;

  function automatic logic [15:0] mergeStrb(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    mergeStrb = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : mergeStrb

  logic [15:0] muteWord;
  assign muteWord = {5'h00, autoMute_r, rampDis_r, manual_r};
  assign wrData   = mergeStrb(muteWord, pwdata, pstrb);

  logic [7:0] lockGain;
  logic [7:0] lockLoss;
  assign lockGain = lock_nxt & ~lock_r;
  assign lockLoss = ~lock_nxt & lock_r;

  always_comb begin
    apbState_nxt = apbState_r;
    prdata_nxt   = 32'h00000000;
    pready_nxt   = 1'b0;
    pslverr_nxt  = 1'b0;
    manual_nxt   = manual_r;
    rampDis_nxt  = rampDis_r;
    autoMute_nxt = autoMute_r;
    irqMask_nxt  = irqMask_r;
    irqStat_nxt  = irqStat_r;
    unique case (apbState_r)
      slmc_pkg::SLMC_IDLE: begin
        if (psel && !penable) begin
          apbState_nxt = slmc_pkg::SLMC_ACCESS;
        end
      end
      slmc_pkg::SLMC_ACCESS: begin
        pready_nxt   = !pready;
        apbState_nxt = pready ? slmc_pkg::SLMC_IDLE : slmc_pkg::SLMC_ACCESS;
        if (isIdx(paddr, `SLMC_IDX_LOCK_FLAGS)) begin
          prdata_nxt = {24'h000000, lock_r};
        end else if (isIdx(paddr, `SLMC_IDX_MUTE_CONTROL)) begin
          prdata_nxt = {16'h0000, muteWord};
          if (wrHit && pready) begin
            manual_nxt   = wrData[7:0];
            rampDis_nxt  = {wrData[`SLMC_MUTE_RAMP1_BIT], wrData[`SLMC_MUTE_RAMP0_BIT]};
            autoMute_nxt = wrData[`SLMC_MUTE_AUTO_BIT];
          end
        end else if (isIdx(paddr, `SLMC_IDX_IRQ_STATUS)) begin
          prdata_nxt = {16'h0000, irqStat_r};
          if (rdHit && pready) begin
            // clear only what was reported, so an event after the answer survives
            irqStat_nxt = irqStat_r & ~prdata[15:0];
          end
        end else if (isIdx(paddr, `SLMC_IDX_IRQ_MASK)) begin
          prdata_nxt = {16'h0000, irqMask_r};
          if (wrHit && pready) begin
            irqMask_nxt = mergeStrb(irqMask_r, pwdata, pstrb);
          end
        end else begin
          pslverr_nxt = !pready;
        end
        if (pready) begin
          prdata_nxt = 32'h00000000;
        end
      end
      default: apbState_nxt = slmc_pkg::SLMC_IDLE;
    endcase
    // new events win over the read clear
    irqStat_nxt = irqStat_nxt | {lockLoss, lockGain};
    irq_nxt     = |(irqStat_nxt & irqMask_nxt);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      apbState_r <= slmc_pkg::SLMC_IDLE;
      prdata     <= 32'h00000000;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      lock_r     <= 8'(`SLMC_LOCK_FLAGS_RESET);
      {autoMute_r, rampDis_r, manual_r} <= 11'(`SLMC_MUTE_RESET);
      irqStat_r  <= 16'h0000;
      irqMask_r  <= `SLMC_IRQ_MASK_RESET;
      irq        <= 1'b0;
    end else begin
      apbState_r <= apbState_nxt;
      prdata     <= prdata_nxt;
      pready     <= pready_nxt;
      pslverr    <= pslverr_nxt;
      lock_r     <= lock_nxt;
      manual_r   <= manual_nxt;
      rampDis_r  <= rampDis_nxt;
      autoMute_r <= autoMute_nxt;
      irqStat_r  <= irqStat_nxt;
      irqMask_r  <= irqMask_nxt;
      irq        <= irq_nxt;
    end
  end

  // ======================================================================
  // gain and mute outputs
  // ======================================================================
  logic [8*12-1:0] pairGain_nxt;
  logic [7:0]      pairMuted_nxt;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      pairGain_nxt[i*12 +: 12] = gain_nxt[i];
      pairMuted_nxt[i]         = (gain_nxt[i] == 12'h000);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pairGain  <= {8{`SLMC_GAIN_FULL}};
      pairMuted <= 8'h00;
    end else begin
      pairGain  <= pairGain_nxt;
      pairMuted <= pairMuted_nxt;
    end
  end

  // ======================================================================
  // checks
  // ======================================================================
  sequence s_lockCondAll(int n);
    condS.rateSet[n] && condS.inputStable[n] && condS.ratioDone[n];
  endsequence

  a_lock_follows_cond: assert property (@(posedge clk) disable iff (rst)
    lock_nxt[0] == (condS.rateSet[0] & condS.inputStable[0] & condS.ratioDone[0]) ##1 1'b1
    |-> lock_r[0] == $past(condS.rateSet[0] & condS.inputStable[0] & condS.ratioDone[0]))
    else $error("lock flag does not follow its conditions");

  a_lock_only_all: assert property (@(posedge clk) disable iff (rst)
    lock_r[3] |-> $past(condS.rateSet[3] && condS.ratioDone[3] && condS.inputStable[3]))
    else $error("lock flag set without all conditions");

  a_lock_readonly: assert property (@(posedge clk) disable iff (rst)
    wrHit && pready && isIdx(paddr, `SLMC_IDX_LOCK_FLAGS)
    |=> lock_r == $past(condS.rateSet & condS.inputStable & condS.ratioDone))
    else $error("lock flags changed by a write");

  a_group_keep_full: assert property (@(posedge clk) disable iff (rst)
    rampDis_r[0] |=> gain_r[2] == `SLMC_GAIN_FULL)
    else $error("disabled group not held at full gain");

  a_group1_split: assert property (@(posedge clk) disable iff (rst)
    rampDis_r[1] && !rampDis_r[0] && manual_r[1] && sampleStep[1] && gain_r[1] != 12'h000
    |=> gain_r[1] == $past(gain_r[1]) - 12'h001)
    else $error("group 0 pair followed group 1 disable");

  a_manual_override: assert property (@(posedge clk) disable iff (rst)
    !rampDis_r[0] && manual_r[0] && lock_r[0] |-> wantMute[0])
    else $error("manual mute overridden by lock");

  a_auto_off: assert property (@(posedge clk) disable iff (rst)
    !autoMute_r && !manual_r[5] |-> !wantMute[5])
    else $error("pair muted with auto mute cleared");

  a_auto_on: assert property (@(posedge clk) disable iff (rst)
    autoMute_r && !lock_r[6] && !rampDis_r[1] |-> wantMute[6])
    else $error("unlocked pair not auto muted");

  a_ramp_step: assert property (@(posedge clk) disable iff (rst)
    !groupDis(rampDis_r, 4) && !sampleStep[4] |=> gain_r[4] == $past(gain_r[4]))
    else $error("gain moved without an input sample");

  a_ramp_down: assert property (@(posedge clk) disable iff (rst)
    wantMute[7] && sampleStep[7] && gain_r[7] != 12'h000 |=> gain_r[7] == $past(gain_r[7]) - 12'h001)
    else $error("mute ramp not one step per sample");

  a_ramp_up: assert property (@(posedge clk) disable iff (rst)
    !wantMute[7] && !rampDis_r[1] && sampleStep[7] && gain_r[7] != `SLMC_GAIN_FULL
    |=> gain_r[7] == $past(gain_r[7]) + 12'h001)
    else $error("unmute ramp not one step per sample");

  a_ramp_bound: assert property (@(posedge clk) disable iff (rst)
    gain_r[0] <= `SLMC_GAIN_FULL)
    else $error("gain exceeds full scale");

  a_manual_store: assert property (@(posedge clk) disable iff (rst)
    wrHit && pready && isIdx(paddr, `SLMC_IDX_MUTE_CONTROL) && pstrb[0] |=> manual_r == $past(pwdata[7:0]))
    else $error("manual mute not stored");

  a_ramp_bits: assert property (@(posedge clk) disable iff (rst)
    wrHit && pready && isIdx(paddr, `SLMC_IDX_MUTE_CONTROL) && pstrb[1] |=> rampDis_r == $past(pwdata[9:8]))
    else $error("ramp disable bits not stored");

  a_reverse: assert property (@(posedge clk) disable iff (rst)
    $changed(wantMute[2]) && !rampDis_r[0]
    |=> gain_r[2] == $past(gain_r[2]) || gain_r[2] == $past(gain_r[2]) + 12'h001
        || gain_r[2] == $past(gain_r[2]) - 12'h001)
    else $error("gain jumped on target reversal");

endmodule : slmc_lock_mute

// [testbench/tb_top.sv]
`timescale 1ns/1ps
`include "slmc_defs.svh"

module tb_top;
  // ==========================================================
  // addresses and constants
  localparam logic [31:0] A_LOCK = {14'h0, `SLMC_IDX_LOCK_FLAGS, 2'b00};
  localparam logic [31:0] A_MUTE = {14'h0, `SLMC_IDX_MUTE_CONTROL, 2'b00};
  localparam logic [31:0] A_STAT = {14'h0, `SLMC_IDX_IRQ_STATUS, 2'b00};
  localparam logic [31:0] A_MASK = {14'h0, `SLMC_IDX_IRQ_MASK, 2'b00};
  localparam logic [31:0] A_BAD  = 32'h0003d610;
  localparam logic [31:0] FULL   = 32'h00000800;

  // ==========================================================
  // signals
  logic                      clk;
  logic                      rst;
  logic                      psel;
  logic                      penable;
  logic                      pwrite;
  logic [31:0]               paddr;
  logic [31:0]               pwdata;
  logic [3:0]                pstrb;
  logic [31:0]               prdata;
  logic                      pready;
  logic                      pslverr;
  slmc_pkg::slmc_lock_cond_t lockCond;
  logic [7:0]                sampleTick;
  logic [8*12-1:0]           pairGain;
  logic [7:0]                pairMuted;
  logic                      irq;
  int                        failures;
  int                        nCompared;
  logic [31:0]               rd;
  logic                      err;

  slmc_lock_mute slmc_lock_mute_i (
    .clk        (clk),
    .rst        (rst),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .pstrb      (pstrb),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .lockCond   (lockCond),
    .sampleTick (sampleTick),
    .pairGain   (pairGain),
    .pairMuted  (pairMuted),
    .irq        (irq)
  );

  always #12.5 clk = ~clk;

  // ==========================================================
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    if (failures == 0 && nCompared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] g(input int n);
    return {20'h0, pairGain[12*n +: 12]};
  endfunction : g

  // ==========================================================
  // bus and stimulus tasks
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (pready !== 1'b1) begin
      failures++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd, exp);
  endtask : rd_chk

  // one toggle is one input sample; spacing leaves room for the synchroniser
  task automatic tick(input logic [7:0] m, input int n);
    repeat (n) begin
      @(posedge clk);
      sampleTick <= sampleTick ^ m;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask : tick

  task automatic set_lock(input logic [23:0] v);
    @(posedge clk);
    lockCond <= v;
    repeat (8) @(posedge clk);
  endtask : set_lock

  // ==========================================================
  // main sequence
  initial begin
    clk = 1'b0; rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 32'h0; pwdata = 32'h0; pstrb = 4'hf; lockCond = '0; sampleTick = 8'h00;
    failures = 0; nCompared = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd_chk(A_LOCK, 32'h0);
    rd_chk(A_MUTE, 32'h0);
    chk(g(5), FULL);
    chk({24'h0, pairMuted}, 32'h0);
    wr(A_MUTE, 32'hffffffff);
    rd_chk(A_MUTE, 32'h000007ff);
    wr(A_MUTE, 32'h0);
    pstrb <= 4'h2;
    wr(A_MUTE, 32'hffffffff);
    pstrb <= 4'hf;
    rd_chk(A_MUTE, 32'h00000700);
    wr(A_MUTE, 32'h0);
    apb(1'b0, A_BAD, 32'h0, rd, err);
    chk({31'h0, err}, 32'h1);
    // lock is the and of the three conditions, bit n for pair n
    wr(A_MASK, 32'h0000ffff);
    set_lock({8'hff, 8'hf0, 8'h3c});
    rd_chk(A_LOCK, 32'h00000030);
    set_lock({8'hff, 8'hff, 8'ha5});
    rd_chk(A_LOCK, 32'h000000a5);
    set_lock({8'hff, 8'hff, 8'hff});
    chk({31'h0, irq}, 32'h1);
    rd_chk(A_STAT, 32'h000010ff);
    @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(A_LOCK, 32'h0);
    rd_chk(A_LOCK, 32'h000000ff);
    // a masked loss event stays pending without raising the line
    wr(A_MASK, 32'h000000ff);
    set_lock({8'hff, 8'hff, 8'hfb});
    chk({31'h0, irq}, 32'h0);
    rd_chk(A_STAT, 32'h00000400);
    set_lock({8'hff, 8'hff, 8'hff});
    chk({31'h0, irq}, 32'h1);
    rd_chk(A_STAT, 32'h00000004);
    // manual mute ramp with pair 1 unlocked and auto mute off
    set_lock({8'hff, 8'hff, 8'hfd});
    wr(A_MUTE, 32'h1);
    tick(8'hff, 1024);
    chk(g(0), 32'h400);
    chk(g(1), FULL);
    tick(8'hff, 1024);
    chk(g(0), 32'h0);
    chk({24'h0, pairMuted}, 32'h1);
    // reversal mid-ramp
    wr(A_MUTE, 32'h0);
    tick(8'h01, 100);
    chk(g(0), 32'h64);
    wr(A_MUTE, 32'h1);
    tick(8'h01, 40);
    chk(g(0), 32'h3c);
    wr(A_MUTE, 32'h0);
    tick(8'h01, 1988);
    chk(g(0), FULL);
    chk({24'h0, pairMuted}, 32'h0);
    // group disable bits
    wr(A_MUTE, 32'h2ff);
    tick(8'hff, 16);
    chk(g(3), 32'h7f0);
    chk(g(4), FULL);
    wr(A_MUTE, 32'h1ff);
    repeat (4) @(posedge clk);
    chk(g(3), FULL);
    tick(8'hff, 16);
    chk(g(7), 32'h7f0);
    chk(g(0), FULL);
    wr(A_MUTE, 32'h0);
    tick(8'hff, 16);
    chk(g(7), FULL);
    // automatic mute of the unlocked pair 1
    wr(A_MUTE, 32'h400);
    tick(8'h03, 1024);
    chk(g(1), 32'h400);
    chk(g(0), FULL);
    tick(8'h03, 1024);
    chk(g(1), 32'h0);
    wr(A_MUTE, 32'h402);
    set_lock({8'hff, 8'hff, 8'hff});
    tick(8'h02, 16);
    chk(g(1), 32'h0);
    wr(A_MUTE, 32'h400);
    tick(8'h02, 2048);
    chk(g(1), FULL);
    report_and_stop();
  end
endmodule : tb_top
